// ===== rtl/kcs_ctrl.sv
// Kernel clock select controller with AXI4-Lite register slave
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
module kcs_ctrl
  import kcs_pkg::*;
#(
  parameter int NMUX = 4
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // System side
  input  wire logic        external_reset_pin,
  input  wire logic        standby_wake,
  input  wire logic        app_core_started,
  input  wire logic        secure_access,
  input  wire logic [2:0]  boot_pins,
  input  wire logic        stop_exit_req,
  output      logic        stop_exit_ack,
  input  wire logic [NMUX-1:0] src_sync_ok,
  input  wire logic [7:0]  src_enabled,
  output      logic [NMUX-1:0] kernel_gate,
  output      logic [11:0] kernel_sel,
  output      logic [1:0]  boot_source,
  output      logic [5:0]  osc_enable,
  output      logic        mcu_use_internal_osc,
  output      logic        per_from_internal
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic                  aw_got;
    logic                  w_got;
    logic [7:0]            awaddr;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic [NMUX*SEL_W-1:0] sel;
    logic [21:0]           lpdly;
    logic                  trustzone_enable;
    logic                  prot;
    logic [OSC_W-1:0]      osc;
    kcs_mux_type [NMUX-1:0] mux;
    kcs_hs_type            hs;
    logic [21:0]           hs_cnt;
    logic [1:0]            boot;
  } kcs_state_type;

  kcs_state_type s;
  kcs_state_type next_s;

  // Startup pin decode
  function automatic kcs_boot_type boot_decode(input logic [2:0] p);
    case (p)
      3'h0, 3'h6: boot_decode = BOOT_SERIAL;
      3'h1, 3'h7: boot_decode = BOOT_QSPI;
      3'h2, 3'h5: boot_decode = BOOT_CARD;
      3'h3:       boot_decode = BOOT_EXTMEM;
      default:    boot_decode = BOOT_SERIAL;
    endcase
  endfunction : boot_decode

  // Source code to enable index, code offset by mux number in one shared list
  function automatic logic [2:0] src_index(input int m, input logic [2:0] c);
    src_index = 3'(c + 3'(m));
  endfunction : src_index

  logic protected_st;
  assign protected_st = s.trustzone_enable && s.prot && !app_core_started;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [31:0]      wd;
    logic [OSC_W-1:0] osc_w;
    logic [2:0]       nsel;
    logic             en;
    wd     = 32'h0;
    osc_w  = '0;
    nsel   = 3'h0;
    en     = 1'b0;
    next_s = s;
    // Write channel capture
    if (s_axi_awvalid && !s.aw_got) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s.w_got) begin
      next_s.w_got = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    // Write commit once both halves arrived
    if (s.aw_got && s.w_got && !s.bvalid) begin
      wd = s.wdata;
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = 2'h0;
      case (s.awaddr)
        OFS_KERSEL: begin
          for (int m = 0; m < NMUX; m++) begin
            next_s.sel[m*SEL_W +: SEL_W] = wd[m*4 +: SEL_W];
          end
        end
        OFS_LPDLY: next_s.lpdly = wd[21:0];
        OFS_TRUST: begin
          if (secure_access) begin
            next_s.trustzone_enable = wd[TRUST_TRUSTZONE_ENABLE_BIT];
            next_s.prot = wd[TRUST_PROT_BIT];
          end
        end
        OFS_OSCEN: begin
          osc_w = wd[OSC_W-1:0];
          if (protected_st) begin
            osc_w[OSC_HSE_BIT]  = s.osc[OSC_HSE_BIT];
            osc_w[OSC_LSI_BIT]  = s.osc[OSC_LSI_BIT];
            osc_w[OSC_THIRD_PLL_BIT] = s.osc[OSC_THIRD_PLL_BIT];
            osc_w[OSC_KEEP_BIT] = s.osc[OSC_KEEP_BIT];
          end
          if (s.trustzone_enable && !secure_access) begin
            osc_w[OSC_CSI_BIT] = s.osc[OSC_CSI_BIT];
          end
          next_s.osc = osc_w;
        end
        OFS_STATUS: ;
        default: next_s.bresp = 2'h2;
      endcase
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    // Read channel
    if (s_axi_arvalid && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = 2'h0;
      next_s.rdata  = 32'h0;
      case (s_axi_araddr)
        OFS_KERSEL: begin
          for (int m = 0; m < NMUX; m++) begin
            next_s.rdata[m*4 +: SEL_W] = s.sel[m*SEL_W +: SEL_W];
          end
        end
        OFS_LPDLY:  next_s.rdata[21:0] = s.lpdly;
        OFS_TRUST:  next_s.rdata[1:0] = {s.prot, s.trustzone_enable};
        OFS_OSCEN: begin
          next_s.rdata[OSC_W-1:0] = s.osc;
          if (protected_st && !secure_access) begin
            next_s.rdata[OSC_KEEP_BIT] = 1'b0;
          end
        end
        OFS_STATUS: begin
          for (int m = 0; m < NMUX; m++) begin
            next_s.rdata[m*4 +: SEL_W] = s.mux[m].cur;
            next_s.rdata[m*4+3]        = s.mux[m].gate;
          end
          next_s.rdata[17:16] = s.boot;
          next_s.rdata[20]    = protected_st;
          next_s.rdata[21]    = (s.hs == HS_HOLD);
        end
        default: next_s.rresp = 2'h2;
      endcase
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    // Glitch-free switch sequencing per mux
    for (int m = 0; m < NMUX; m++) begin
      nsel = s.sel[m*SEL_W +: SEL_W];
      en   = src_enabled[src_index(m, s.mux[m].cur)];
      case (s.mux[m].st)
        SW_RUN: begin
          next_s.mux[m].gate = en;
          if (nsel != s.mux[m].cur) begin
            next_s.mux[m].pend = nsel;
            next_s.mux[m].gate = 1'b0;
            next_s.mux[m].st   = SW_OFF;
          end
        end
        SW_OFF: begin
          if (src_sync_ok[m]) begin
            next_s.mux[m].cur = s.mux[m].pend;
            next_s.mux[m].st  = SW_ON;
          end
        end
        SW_ON: begin
          if (src_sync_ok[m]) begin
            next_s.mux[m].gate = en;
            next_s.mux[m].st   = SW_RUN;
          end
        end
        default: next_s.mux[m].st = SW_RUN;
      endcase
    end
    // Stop exit handshake holds for the programmed delay
    case (s.hs)
      HS_IDLE: begin
        if (stop_exit_req) begin
          next_s.hs     = HS_HOLD;
          next_s.hs_cnt = s.lpdly;
        end
      end
      HS_HOLD: begin
        if (s.hs_cnt != 22'h0) begin
          next_s.hs_cnt = s.hs_cnt - 22'h1;
        end else if (!stop_exit_req) begin
          next_s.hs = HS_IDLE;
        end
      end
      default: next_s.hs = HS_IDLE;
    endcase
    // Standby wake forces protection defaults
    if (standby_wake) begin
      next_s.trustzone_enable = 1'b1;
      next_s.prot = 1'b1;
    end
    // Protected state removes forbidden sources
    if (next_s.trustzone_enable && next_s.prot && !app_core_started) begin
      next_s.osc[OSC_HSE_BIT]  = 1'b0;
      next_s.osc[OSC_LSI_BIT]  = 1'b0;
      next_s.osc[OSC_THIRD_PLL_BIT] = 1'b0;
    end
    next_s.boot = boot_decode(boot_pins);
    // Pin reset returns all switches to default
    if (external_reset_pin) begin
      for (int m = 0; m < NMUX; m++) begin
        next_s.sel[m*SEL_W +: SEL_W] = SEL_RESET;
        next_s.mux[m].cur  = SEL_RESET;
        next_s.mux[m].pend = SEL_RESET;
        next_s.mux[m].st   = SW_RUN;
        next_s.mux[m].gate = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s        <= '0;
      s.trustzone_enable   <= 1'b1;
      s.prot   <= 1'b1;
      s.lpdly  <= LPDLY_RESET;
      s.osc    <= OSC_RESET;
      s.hs     <= HS_IDLE;
      for (int m = 0; m < NMUX; m++) begin
        s.mux[m].st  <= SW_RUN;
        s.mux[m].cur <= SEL_RESET;
      end
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign s_axi_awready = !s.aw_got;
  assign s_axi_wready  = !s.w_got;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;
  assign stop_exit_ack = (s.hs == HS_HOLD);
  assign boot_source   = s.boot;
  assign osc_enable    = s.osc;
  assign mcu_use_internal_osc = protected_st;
  assign per_from_internal    = protected_st;

  // Gates and current selections per switch
  genvar g;
  generate
    for (g = 0; g < NMUX; g++) begin : g_mux
      assign kernel_gate[g] = s.mux[g].gate;
      assign kernel_sel[g*SEL_W +: SEL_W] = s.mux[g].cur;
    end
  endgenerate

endmodule : kcs_ctrl

// ===== rtl/kcs_pkg.sv
// Package of constants and types for the kernel clock select controller
// ----------------------------------------------------------------------
// Contract
// - External reset returns every clock switch default
// - Card source: 0 bus clock six, 3 oscillator
// - Serial source: 0 peripheral bus, 2 oscillator
// - Quad flash source: 0 interconnect, 3 common
// - Extmem source: 0 interconnect, 3 common clock
// - Startup pins decode to boot peripheral
// - Standby wake sets trust and protect bits
// - Protected state blocks oscillators, core uses internal
// - Protected: only fourth pll, common from internal
// - Protected: keep-on bit hidden from core
// - Standby exit secures low-power oscillator enable
// - Stop exit handshake holds state long enough
// ----------------------------------------------------------------------
package kcs_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_KERSEL  = 8'h00;
  localparam logic [7:0] OFS_LPDLY   = 8'h04;
  localparam logic [7:0] OFS_TRUST   = 8'h08;
  localparam logic [7:0] OFS_OSCEN   = 8'h0c;
  localparam logic [7:0] OFS_STATUS  = 8'h10;

  // Kernel select field positions in the select register
  localparam int SEL_CARD_LSB   = 0;
  localparam int SEL_SER_LSB    = 4;
  localparam int SEL_QSPI_LSB   = 8;
  localparam int SEL_EXTM_LSB   = 12;
  localparam int SEL_W          = 3;

  // Trust control register bits
  localparam int TRUST_TRUSTZONE_ENABLE_BIT = 0;
  localparam int TRUST_PROT_BIT = 1;

  // Oscillator enable register bits
  localparam int OSC_HSE_BIT    = 0;
  localparam int OSC_CSI_BIT    = 1;
  localparam int OSC_LSI_BIT    = 2;
  localparam int OSC_THIRD_PLL_BIT   = 3;
  localparam int OSC_FOURTH_PLL_BIT   = 4;
  localparam int OSC_KEEP_BIT   = 5;
  localparam int OSC_W          = 6;

  // Reset values and minimum stop exit delay
  localparam logic [2:0]  SEL_RESET    = 3'h0;
  localparam logic [21:0] LPDLY_RESET  = 22'h000000;
  localparam logic [21:0] LPDLY_MIN    = 22'h000004;
  localparam logic [5:0]  OSC_RESET    = 6'h00;

  // Source codes
  localparam logic [2:0] CARD_BUS6     = 3'h0;
  localparam logic [2:0] CARD_HSI      = 3'h3;
  localparam logic [2:0] SER_PCLK      = 3'h0;
  localparam logic [2:0] SER_HSI       = 3'h2;
  localparam logic [2:0] MEM_ACLK      = 3'h0;
  localparam logic [2:0] MEM_PER       = 3'h3;

  // Startup decode
  typedef enum logic [1:0] {
    BOOT_SERIAL = 2'h0,
    BOOT_QSPI   = 2'h1,
    BOOT_CARD   = 2'h2,
    BOOT_EXTMEM = 2'h3
  } kcs_boot_type;

  // Clock switch sequencing, one-hot
  typedef enum logic [2:0] {
    SW_RUN  = 3'b001,
    SW_OFF  = 3'b010,
    SW_ON   = 3'b100
  } kcs_sw_type;

  // Stop exit handshake, one-hot
  typedef enum logic [1:0] {
    HS_IDLE = 2'b01,
    HS_HOLD = 2'b10
  } kcs_hs_type;

  // Per-switch state
  typedef struct packed {
    kcs_sw_type  st;
    logic [2:0]  cur;
    logic [2:0]  pend;
    logic        gate;
  } kcs_mux_type;

endpackage : kcs_pkg

// ===== verif/kcs_ctrl_asserts.sv
// Concurrent checks on the kernel clock select controller ports
`timescale 1ns/100ps
module kcs_ctrl_asserts
  import kcs_pkg::*;
#(
  parameter int NMUX = 4
) (
  input wire logic            aclk,
  input wire logic            aresetn,
  input wire logic            s_axi_bvalid,
  input wire logic            s_axi_bready,
  input wire logic            s_axi_rvalid,
  input wire logic            s_axi_rready,
  input wire logic            external_reset_pin,
  input wire logic            standby_wake,
  input wire logic            app_core_started,
  input wire logic [2:0]      boot_pins,
  input wire logic            stop_exit_req,
  input wire logic            stop_exit_ack,
  input wire logic [7:0]      src_enabled,
  input wire logic [NMUX-1:0] kernel_gate,
  input wire logic [11:0]     kernel_sel,
  input wire logic [1:0]      boot_source,
  input wire logic [5:0]      osc_enable,
  input wire logic            mcu_use_internal_osc,
  input wire logic            per_from_internal
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Startup pin decode
  function automatic logic [1:0] boot_of(input logic [2:0] p);
    case (p)
      3'h0, 3'h6: return BOOT_SERIAL;
      3'h1, 3'h7: return BOOT_QSPI;
      3'h2, 3'h5: return BOOT_CARD;
      default:    return BOOT_EXTMEM;
    endcase
  endfunction : boot_of

  // Wake with the application core idle, and a settled protected state
  sequence woke_s;
    standby_wake ##1 !app_core_started;
  endsequence
  sequence held_prot_s;
    mcu_use_internal_osc ##1 mcu_use_internal_osc;
  endsequence

  ext_reset_sel_a : assert property (
    external_reset_pin |=> kernel_sel == 12'h000 && kernel_gate == '0)
    else $error("kernel switches not at default after reset pin");
  wake_protect_a : assert property (
    woke_s |-> mcu_use_internal_osc && per_from_internal)
    else $error("protected state missing after standby wake");
  prot_osc_off_a : assert property (
    held_prot_s |-> !osc_enable[OSC_HSE_BIT] && !osc_enable[OSC_LSI_BIT]
      && !osc_enable[OSC_THIRD_PLL_BIT])
    else $error("blocked oscillator enabled in protected state");
  no_src_gate_a : assert property (
    (!src_enabled[kernel_sel[2:0]]) [*2] |-> !kernel_gate[0])
    else $error("kernel clock passed from a disabled source");
  exit_ack_a : assert property (
    $rose(stop_exit_req) && !stop_exit_ack |=> stop_exit_ack)
    else $error("stop exit not answered in one cycle");
  exit_hold_a : assert property (
    stop_exit_ack && stop_exit_req |=> stop_exit_ack)
    else $error("stop exit answer dropped while request high");
  boot_decode_a : assert property (
    boot_pins != 3'h4 |=> boot_source == boot_of($past(boot_pins)))
    else $error("startup source decode wrong");
  resp_hold_a : assert property (
    (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      and (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid))
    else $error("bus response withdrawn before taken");
endmodule : kcs_ctrl_asserts

bind kcs_ctrl kcs_ctrl_asserts #(.NMUX(NMUX)) u_asserts (.*);

// ===== verif/kcs_ctrl_tb.sv
// Self-checking bench of the kernel clock select controller
`timescale 1ns/100ps
module kcs_ctrl_tb
  import kcs_pkg::*;
();
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, boot_source, rd_resp, wr_resp;
  logic        external_reset_pin = 1'h0, standby_wake = 1'h0;
  logic        app_core_started = 1'h0, secure_access = 1'h0;
  logic        stop_exit_req = 1'h0, stop_exit_ack;
  logic [2:0]  boot_pins = 3'h0;
  logic [3:0]  src_sync_ok = 4'hf, kernel_gate;
  logic [7:0]  src_enabled = 8'hff;
  logic [11:0] kernel_sel;
  logic [5:0]  osc_enable;
  logic        mcu_use_internal_osc, per_from_internal;
  logic [1:0]  bexp [8] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h2, 2'h0, 2'h1};
  int          mismatches = 0, samples_checked = 0;

  kcs_ctrl #(.NMUX(4)) uut (.*);

  // Bus clock, 40 ns period
  always #20 aclk = ~aclk;

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic hang(input string nm);
    mismatches++;
    $display("unexpected %s: expected answer seen timeout", nm);
    results();
  endtask : hang

  // ----------------------------------------------------------------------
  // Register bus master
  // ----------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 60; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    wr_resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
    if (n == 60) hang("write response");
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 60; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
    if (n == 60) hang("read data");
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk("register", e, rd_data);
  endtask : rchk

  // Wait for the switches to settle, then compare codes and gates
  task automatic wk(input logic [11:0] s, input logic [3:0] g);
    for (int n = 0; n < 80 && (kernel_sel !== s || kernel_gate !== g); n++)
      @(posedge aclk);
    chk("kernel select", {20'h0, s}, {20'h0, kernel_sel});
    chk("kernel gate", {28'h0, g}, {28'h0, kernel_gate});
  endtask : wk

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    int n;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    rchk(OFS_KERSEL, 32'h0);
    rchk(OFS_TRUST, 32'h3);
    rchk(OFS_OSCEN, 32'h0);
    rd(8'h14);
    chk("unmapped response", 32'h2, {30'h0, rd_resp});
    wr(8'h14, 32'h0);
    chk("unmapped write response", 32'h2, {30'h0, wr_resp});
    // Codes 0 to 3 on all four switches, then the documented pair
    for (int c = 0; c < 4; c++) begin
      wr(OFS_KERSEL, 32'h1111 * c);
      wk(12'(12'h249 * c), 4'hf);
    end
    wr(OFS_KERSEL, 32'h3323);
    wk(12'h6d3, 4'hf);
    src_enabled <= 8'h00;
    wk(12'h6d3, 4'h0);
    src_enabled <= 8'hff;
    wk(12'h6d3, 4'hf);
    // Switch held until both clocks are synchronised
    src_sync_ok <= 4'h0;
    wr(OFS_KERSEL, 32'h0);
    repeat (8) @(posedge aclk);
    chk("gate before sync", 32'h0, {28'h0, kernel_gate});
    src_sync_ok <= 4'hf;
    wk(12'h000, 4'hf);
    // Reset pin pulse in mid-run
    wr(OFS_KERSEL, 32'h3323);
    wk(12'h6d3, 4'hf);
    external_reset_pin <= 1'h1;
    @(posedge aclk);
    external_reset_pin <= 1'h0;
    repeat (2) @(posedge aclk);
    chk("select after pin", 32'h0, {20'h0, kernel_sel});
    rchk(OFS_KERSEL, 32'h0);
    // Startup pin decode
    for (int p = 0; p < 8; p++) begin
      boot_pins <= 3'(p);
      repeat (2) @(posedge aclk);
      if (p != 4) chk("boot source", {30'h0, bexp[p]}, {30'h0, boot_source});
    end
    // Stop exit handshake with the minimum delay
    wr(OFS_LPDLY, 32'h4);
    rchk(OFS_LPDLY, 32'h4);
    stop_exit_req <= 1'h1;
    n = 0;
    repeat (40) begin
      @(posedge aclk);
      if (stop_exit_ack === 1'h1) n++;
      if (n == 2) stop_exit_req <= 1'h0;
    end
    chk("exit answer held", 32'h1, {31'h0, n >= 5});
    chk("exit answer end", 32'h0, {31'h0, stop_exit_ack});
    // Lift protection, then a standby wake restores it
    app_core_started <= 1'h1;
    secure_access <= 1'h1;
    wr(OFS_TRUST, 32'h0);
    rchk(OFS_TRUST, 32'h0);
    standby_wake <= 1'h1;
    @(posedge aclk);
    standby_wake <= 1'h0;
    app_core_started <= 1'h0;
    rchk(OFS_TRUST, 32'h3);
    chk("core osc", 32'h1, {31'h0, mcu_use_internal_osc});
    chk("common clock", 32'h1, {31'h0, per_from_internal});
    secure_access <= 1'h0;
    wr(OFS_OSCEN, 32'h3f);
    rchk(OFS_OSCEN, 32'h10);
    secure_access <= 1'h1;
    wr(OFS_OSCEN, 32'h12);
    rchk(OFS_OSCEN, 32'h12);
    chk("oscillator enables", 32'h12, {26'h0, osc_enable});
    results();
  end
endmodule : kcs_ctrl_tb
